// [nvac_mem_model.sv]
// nvac_mem_model: behavioural data array and program memory facing nvac_top.
// assumes one core clock; reads answer combinationally in the strobe cycle.
`timescale 1ns/1ps
module nvac_mem_model
  import nvac_pkg::*;
(
  input wire logic clock, // core clock
  input wire logic rst, // async reset, active high
  input wire nvac_mem_req_s mem_req, // requests from the block
  input wire logic abort_cmd, // bench asks for an interrupted store
  output logic [7:0] ee_rdata, // data array byte
  output logic [13:0] pm_rdata, // program word
  output logic store_abort_in // store interrupted
);
  logic [7:0] ee [256];
  logic [13:0] pm_word;
  logic wr_q;
  logic ab_q;

  // known start pattern, mirrored by the bench from the same formula
  initial
  begin
    for (int i = 0; i < 256; i++)
      ee[i] = 8'(i * 7 + 3);
  end

  // outside a strobe the answer is inverted so a late or early sample shows up
  assign ee_rdata = mem_req.ee_rd ? ee[mem_req.ee_addr] : ~ee[mem_req.ee_addr];
  // program memory is a fixed pattern and never written
  assign pm_word = 14'(mem_req.pm_addr * 13 + 5);
  assign pm_rdata = mem_req.pm_rd ? pm_word : ~pm_word;
  assign store_abort_in = abort_cmd & mem_req.ee_wr;

  // the byte lands when the store level falls, unless it was interrupted
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wr_q <= 1'b0;
      ab_q <= 1'b0;
    end
    else
    begin
      wr_q <= mem_req.ee_wr;
      if (!mem_req.ee_wr)
        ab_q <= 1'b0;
      else if (store_abort_in)
        ab_q <= 1'b1;
      if (wr_q && !mem_req.ee_wr && !ab_q)
        ee[mem_req.ee_addr] <= mem_req.ee_wdata;
    end
  end
endmodule : nvac_mem_model

// [nvac_pkg.sv]
// nvac_pkg: constants, types and register map of the nonvolatile access block.
// assumes one 50 MHz core clock shared by the bus, the block and the arrays.
package nvac_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] OFF_DATA_LOW = 8'h00;
  localparam logic [7:0] OFF_ADDR_LOW = 8'h04;
  localparam logic [7:0] OFF_WORD_HIGH = 8'h08;
  localparam logic [7:0] OFF_ADDR_HIGH = 8'h0c;
  localparam logic [7:0] OFF_CONTROL = 8'h10;
  localparam logic [7:0] OFF_UNLOCK = 8'h14;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h1c;

  // field widths and positions
  localparam int WORD_HIGH_W = 6;
  localparam int ADDR_HIGH_W = 4;
  localparam int CTL_SEL = 7;
  localparam int CTL_ABORT = 3;
  localparam int CTL_PERMIT = 2;
  localparam int CTL_WR = 1;
  localparam int CTL_RD = 0;
  localparam int IRQ_W = 3;
  localparam int IRQ_STORE_DONE = 0;
  localparam int IRQ_READ_DONE = 1;
  localparam int IRQ_STORE_REFUSED = 2;

  // values after reset
  localparam logic [7:0] RST_DATA_LOW = 8'h00;
  localparam logic [7:0] RST_ADDR_LOW = 8'h00;
  localparam logic [5:0] RST_WORD_HIGH = 6'h00;
  localparam logic [3:0] RST_ADDR_HIGH = 4'h0;
  localparam logic [2:0] RST_IRQ = 3'h0;

  // unlock values written in order to the sequence port
  localparam logic [7:0] UNLOCK_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'haa;

  // store time; least time, so rounded up to whole cycles
  localparam int CLK_PERIOD_NS = 20;
  localparam int STORE_TIME_NS = 4000;
  localparam int STORE_CYCLES_DEF = (STORE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  // request bundle towards the memory arrays
  typedef struct packed {
    logic [7:0] ee_addr;
    logic [7:0] ee_wdata;
    logic ee_rd;
    logic ee_wr;
    logic [11:0] pm_addr;
    logic pm_rd;
  } nvac_mem_req_s;

  typedef enum logic [1:0] {UNL_IDLE, UNL_FIRST, UNL_ARMED} nvac_unlock_e;

endpackage : nvac_pkg

// [nvac_store_timer.sv]
// nvac_store_timer: times one byte store of the data array.
// assumes start is a one-cycle pulse while idle; abort ends a store at once.
`timescale 1ns/1ps
module nvac_store_timer
  import nvac_pkg::*;
#(
  parameter int CYCLES = STORE_CYCLES_DEF
)
(
  input wire logic clock, // core clock
  input wire logic rst, // async reset, active high
  input wire logic ce, // clock enable
  input wire logic start, // begin a store
  input wire logic abort, // stop the store
  output logic busy, // store in progress
  output logic done // one-cycle pulse at normal end
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  logic [CW-1:0] count;

  // count the store time; done fires in the last counted cycle
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      busy <= 1'b0;
      count <= '0;
    end
    else if (ce)
    begin
      if (start && !busy)
      begin
        busy <= 1'b1;
        count <= '0;
      end
      else if (busy && (abort || count == LAST))
        busy <= 1'b0;
      else if (busy)
        count <= count + CW'(1);
    end
  end

  assign done = ce && busy && !abort && count == LAST;

  // each enabled busy cycle short of the last must advance the count and stay busy
  chk_store_length: assert property (@(posedge clock) disable iff (rst)
    busy && ce && !abort && count != LAST |=> busy && count == $past(count) + CW'(1))
    else $error("store ended early");

endmodule : nvac_store_timer

// [nvac_top.sv]
// nvac_top: register set giving the core access to the data array and program memory.
// assumes an AHB-Lite master on the core clock and arrays answering reads combinationally.
//
// Design decisions made here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module nvac_top
  import nvac_pkg::*;
#(
  parameter int STORE_CYCLES = STORE_CYCLES_DEF
)
(
  input wire logic clock, // core clock, 50 MHz
  input wire logic rst, // async reset, active high
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size, word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data, registered
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  output nvac_mem_req_s mem_req, // requests to the arrays
  input wire logic [7:0] ee_rdata, // data array byte at ee_addr
  input wire logic [13:0] pm_rdata, // program word at pm_addr
  input wire logic store_abort_in, // array reports an interrupted store
  output logic irq // level interrupt
);
  // registers
  logic [7:0] data_low;
  logic [7:0] addr_low;
  logic [WORD_HIGH_W-1:0] word_high;
  logic [ADDR_HIGH_W-1:0] addr_high;
  logic space_select;
  logic store_abort_flag;
  logic store_permit;
  logic ctl_wr;
  logic ctl_rd;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;

  // bus pipeline
  logic wr_pend;
  logic [7:0] wr_addr;
  logic rd_wait;
  logic [7:0] rd_addr;
  logic [7:0] rd_mux;
  logic accept;

  // decoded write strobes
  logic we;
  logic we_data;
  logic we_addr;
  logic we_whigh;
  logic we_ahigh;
  logic we_ctl;
  logic we_unlock;
  logic we_status;
  logic we_mask;
  logic [7:0] wd;

  // store control
  logic armed;
  logic store_go;
  logic store_refused;
  logic store_busy;
  logic store_done;
  logic read_done;
  logic [IRQ_W-1:0] irq_event;

  // address phase accepted; only single word transfers expected
  assign accept = hsel && hready && htrans == HTRANS_NONSEQ;

  // capture address phase; reads get one wait state so hrdata can be a flop
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      rd_wait <= 1'b0;
      rd_addr <= 8'h00;
    end
    else if (ce)
    begin
      wr_pend <= accept && hwrite;
      rd_wait <= accept && !hwrite;
      if (accept)
      begin
        wr_addr <= haddr[7:0];
        rd_addr <= haddr[7:0];
      end
    end
  end

  assign hreadyout = !rd_wait;
  assign hresp = HRESP_OKAY;

  // write decode in the data phase
  assign we = wr_pend && ce;
  assign wd = hwdata[7:0];
  assign we_data = we && wr_addr == OFF_DATA_LOW;
  assign we_addr = we && wr_addr == OFF_ADDR_LOW;
  assign we_whigh = we && wr_addr == OFF_WORD_HIGH;
  assign we_ahigh = we && wr_addr == OFF_ADDR_HIGH;
  assign we_ctl = we && wr_addr == OFF_CONTROL;
  assign we_unlock = we && wr_addr == OFF_UNLOCK;
  assign we_status = we && wr_addr == OFF_IRQ_STATUS;
  assign we_mask = we && wr_addr == OFF_IRQ_MASK;

  // read mux; unimplemented bits and the sequence port read as zero
  always_comb
  begin
    rd_mux = 8'h00;
    unique case (rd_addr)
      OFF_DATA_LOW: rd_mux = data_low;
      OFF_ADDR_LOW: rd_mux = addr_low;
      OFF_WORD_HIGH: rd_mux = {2'b00, word_high};
      OFF_ADDR_HIGH: rd_mux = {4'h0, addr_high};
      OFF_CONTROL: rd_mux = {space_select, 3'b000, store_abort_flag,
                             store_permit, ctl_wr, ctl_rd};
      OFF_IRQ_STATUS: rd_mux = {5'h00, irq_status};
      OFF_IRQ_MASK: rd_mux = {5'h00, irq_mask};
      default: rd_mux = 8'h00;
    endcase
  end

  // read data is sampled in the wait cycle, so a write just before is seen
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      hrdata <= 32'h0000_0000;
    else if (ce && rd_wait)
      hrdata <= {24'h00_0000, rd_mux};
  end

  // data low: software write wins over a read landing in the same cycle
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      data_low <= RST_DATA_LOW;
    else if (ce)
    begin
      if (we_data)
        data_low <= wd;
      else if (ctl_rd && space_select)
        data_low <= pm_rdata[7:0];
      else if (ctl_rd)
        data_low <= ee_rdata;
    end
  end

  // address low
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      addr_low <= RST_ADDR_LOW;
    else if (we_addr)
      addr_low <= wd;
  end

  // word high: written by software in its six bits, loaded by program reads
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      word_high <= RST_WORD_HIGH;
    else if (ce)
    begin
      if (we_whigh)
        word_high <= wd[WORD_HIGH_W-1:0];
      else if (ctl_rd && space_select)
        word_high <= pm_rdata[13:8];
    end
  end

  // address high: upper bits of the write are dropped
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      addr_high <= RST_ADDR_HIGH;
    else if (we_ahigh)
      addr_high <= wd[ADDR_HIGH_W-1:0];
  end

  // select and permit are plain bits; bits 6-4 are not stored
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      space_select <= 1'b0;
      store_permit <= 1'b0;
    end
    else if (we_ctl)
    begin
      space_select <= wd[CTL_SEL];
      store_permit <= wd[CTL_PERMIT];
    end
  end

  // abort flag: array report sets it, and the set wins over a software write
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      store_abort_flag <= 1'b0;
    else if (ce)
    begin
      if (store_busy && store_abort_in)
        store_abort_flag <= 1'b1;
      else if (we_ctl)
        store_abort_flag <= wd[CTL_ABORT];
    end
  end

  // read trigger: set by software, cleared by hardware after one cycle
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      ctl_rd <= 1'b0;
    else if (ce)
    begin
      if (we_ctl && wd[CTL_RD])
        ctl_rd <= 1'b1;
      else if (ctl_rd)
        ctl_rd <= 1'b0;
    end
  end

  // a store needs the unlock, permit, data space and an idle array
  assign store_go = we_ctl && wd[CTL_WR] && !wd[CTL_SEL] && wd[CTL_PERMIT]
                    && armed && !ctl_wr;
  assign store_refused = we_ctl && wd[CTL_WR] && !wd[CTL_SEL] && !ctl_wr && !store_go;

  // write trigger; a zero written here cannot cut a store short
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      ctl_wr <= 1'b0;
    else if (ce)
    begin
      if (store_go)
        ctl_wr <= 1'b1;
      else if (store_done || (store_busy && store_abort_in))
        ctl_wr <= 1'b0;
    end
  end

  nvac_unlock u_unlock (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .port_wr(we_unlock),
    .ctl_wr(we_ctl),
    .other_wr(we && !we_unlock && !we_ctl),
    .wdata(wd),
    .armed(armed)
  );

  nvac_store_timer #(
    .CYCLES(STORE_CYCLES)
  ) u_timer (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .start(store_go),
    .abort(store_abort_in),
    .busy(store_busy),
    .done(store_done)
  );

  // array requests; address and data follow the registers during a store
  always_comb
  begin
    mem_req.ee_addr = addr_low;
    mem_req.ee_wdata = data_low;
    mem_req.ee_rd = ctl_rd && !space_select;
    mem_req.ee_wr = store_busy;
    mem_req.pm_addr = {addr_high, addr_low};
    mem_req.pm_rd = ctl_rd && space_select;
  end

  // interrupt events: store end, read end, refused store
  assign read_done = ce && ctl_rd;
  always_comb
  begin
    irq_event = '0;
    irq_event[IRQ_STORE_DONE] = store_done;
    irq_event[IRQ_READ_DONE] = read_done;
    irq_event[IRQ_STORE_REFUSED] = store_refused;
  end

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      irq_status <= RST_IRQ;
    else if (ce)
      irq_status <= (irq_status & ~(we_status ? wd[IRQ_W-1:0] : '0)) | irq_event;
  end

  // mask register
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      irq_mask <= RST_IRQ;
    else if (we_mask)
      irq_mask <= wd[IRQ_W-1:0];
  end

  assign irq = |(irq_status & irq_mask);

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_data_read;
    ce && ctl_rd && !space_select && !we_data;
  endsequence

  sequence s_prog_read;
    ce && ctl_rd && space_select && !we_data && !we_whigh;
  endsequence

  property p_read_lands;
    logic [7:0] b;
    (s_data_read, b = ee_rdata) |=> data_low == b;
  endproperty

  chk_read_lands: assert property (p_read_lands)
    else $error("data read did not land next cycle");

  chk_read_clears: assert property (ce && ctl_rd && !we_ctl |=> !ctl_rd)
    else $error("read trigger not cleared");

  chk_prog_word: assert property (s_prog_read |=> word_high == $past(pm_rdata[13:8])
    && data_low == $past(pm_rdata[7:0]))
    else $error("program word not loaded");

  chk_whigh_zero: assert property (rd_wait && rd_addr == OFF_WORD_HIGH && ce
    |=> hrdata[7:6] == 2'b00 && hrdata[5:0] == $past(word_high))
    else $error("word high upper bits not zero");

  chk_ahigh_zero: assert property (rd_wait && rd_addr == OFF_ADDR_HIGH && ce
    |=> hrdata[7:4] == 4'h0 && hrdata[3:0] == $past(addr_high))
    else $error("address high upper bits not zero");

  chk_wr_held: assert property (ctl_wr && !store_done && !store_abort_in
    |=> ctl_wr)
    else $error("write trigger dropped early");

  chk_store_unlock: assert property ($rose(ctl_wr) |-> $past(armed)
    && !space_select)
    else $error("store started without unlock");

  chk_pm_addr: assert property (mem_req.pm_rd |-> mem_req.pm_addr[11:8] == addr_high
    && !mem_req.ee_rd)
    else $error("program address wrong");

  chk_done_clears: assert property (store_done |=> !ctl_wr
    && irq_status[IRQ_STORE_DONE])
    else $error("store end not reported");

endmodule : nvac_top

// [nvac_top_tb.sv]
// nvac_top_tb: self-checking bench for nvac_top with an integer register model.
// assumes nvac_mem_model as the arrays and a short store time.
`timescale 1ns/1ps
module nvac_top_tb;
  import nvac_pkg::*;
  localparam int SC = 12;
  logic clock, rst, ce, hsel, hwrite, hreadyout, hresp, irq, abort_cmd, store_abort_in;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] ee_rdata;
  logic [13:0] pm_rdata;
  nvac_mem_req_s mem_req;
  int n_errors, num_checks, m_dl, m_al, m_wh, m_ah, m_ctl, m_st;
  int exp_ee [256];

  nvac_top #(.STORE_CYCLES(SC)) i_dut (.clock(clock), .rst(rst), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .mem_req(mem_req), .ee_rdata(ee_rdata), .pm_rdata(pm_rdata),
    .store_abort_in(store_abort_in), .irq(irq));
  nvac_mem_model i_mem (.clock(clock), .rst(rst), .mem_req(mem_req), .abort_cmd(abort_cmd),
    .ee_rdata(ee_rdata), .pm_rdata(pm_rdata), .store_abort_in(store_abort_in));

  // 50 MHz core clock
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task print_verdict;
    if (n_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // irq looked at mid-cycle, once the last write has landed
  task chk_irq(input logic e);
    @(negedge clock);
    num_checks++;
    if (irq !== e)
    begin
      n_errors++;
      $display("[ERR] irq exp %b got %b", e, irq);
    end
    @(posedge clock);
  endtask : chk_irq

  // ready is judged mid-cycle so the accepting edge is known; data taken with it
  task wait_acc;
    int n;
    n = 0;
    @(negedge clock);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        n_errors++;
        $display("[ERR] hreadyout exp 1 got %b", hreadyout);
        print_verdict;
      end
      @(negedge clock);
    end
    rv = hrdata;
    @(posedge clock);
  endtask : wait_acc

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_acc;
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_acc;
  endtask : bus

  // write and mirror the effect in the model
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    case (a)
      OFF_DATA_LOW: m_dl = d & 8'hff;
      OFF_ADDR_LOW: m_al = d & 8'hff;
      OFF_WORD_HIGH: m_wh = d & 8'h3f;
      OFF_ADDR_HIGH: m_ah = d & 8'h0f;
      OFF_CONTROL: m_ctl = d & 8'h8c;
      OFF_IRQ_STATUS: m_st = m_st & ~d;
      default: ;
    endcase
  endtask : wr

  task rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rv);
  endtask : rdc

  task ee_read(input logic [7:0] a);
    wr(OFF_ADDR_LOW, a);
    wr(OFF_CONTROL, 32'h1);
    m_dl = exp_ee[a];
    m_st = m_st | 2;
    rdc(OFF_DATA_LOW, m_dl, "ee byte");
    rdc(OFF_CONTROL, m_ctl, "control after read");
  endtask : ee_read

  task pm_read(input logic [11:0] a);
    int w;
    wr(OFF_ADDR_HIGH, a[11:8]);
    wr(OFF_ADDR_LOW, a[7:0]);
    wr(OFF_CONTROL, 32'h81);
    w = (a * 13 + 5) & 16'h3fff;
    m_dl = w & 8'hff;
    m_wh = w >> 8;
    m_st = m_st | 2;
    rdc(OFF_DATA_LOW, m_dl, "pm low");
    rdc(OFF_WORD_HIGH, m_wh, "pm high");
    rdc(OFF_CONTROL, 32'h80, "control pm");
  endtask : pm_read

  // unlock pair then trigger; brk slips another write into the pair
  task store(input logic [7:0] a, input logic [7:0] d, input logic [31:0] c, input bit brk);
    wr(OFF_ADDR_LOW, a);
    wr(OFF_DATA_LOW, d);
    wr(OFF_UNLOCK, UNLOCK_FIRST);
    if (brk)
      wr(OFF_ADDR_LOW, a);
    wr(OFF_UNLOCK, UNLOCK_SECOND);
    wr(OFF_CONTROL, c);
  endtask : store

  // main sequence
  initial
  begin
    logic [7:0] a;
    logic [7:0] d;
    int n;
    rv = $urandom(32'h7367);
    rst = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    abort_cmd = 1'b0;
    ce = 1'b1;
    m_dl = 0; m_al = 0; m_wh = 0; m_ah = 0; m_ctl = 0; m_st = 0;
    for (int i = 0; i < 256; i++)
      exp_ee[i] = (i * 7 + 3) & 8'hff;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 9; i++)
      rdc(8'(i * 4), 32'h0, "reset value");
    for (int i = 0; i < 4; i++)
    begin
      wr(OFF_DATA_LOW, $urandom);
      wr(OFF_ADDR_LOW, $urandom);
      wr(OFF_WORD_HIGH, $urandom);
      wr(OFF_ADDR_HIGH, $urandom);
      rdc(OFF_DATA_LOW, m_dl, "data_low");
      rdc(OFF_ADDR_LOW, m_al, "addr_low");
      rdc(OFF_WORD_HIGH, m_wh, "word_high");
      rdc(OFF_ADDR_HIGH, m_ah, "addr_high");
    end
    wr(OFF_CONTROL, 32'h70);
    rdc(OFF_CONTROL, 32'h0, "control unused");
    wr(8'h20, 32'hff);
    rdc(8'h20, 32'h0, "unmapped");
    rdc(OFF_UNLOCK, 32'h0, "unlock port");
    ee_read(8'hff);
    for (int i = 0; i < 5; i++)
      ee_read(8'($urandom));
    for (int i = 0; i < 4; i++)
      pm_read(i == 0 ? 12'hfff : 12'($urandom));
    // good store, with a zero written to the trigger while busy
    a = 8'($urandom);
    d = 8'($urandom);
    store(a, d, 32'h06, 1'b0);
    wr(OFF_CONTROL, 32'h04);
    rdc(OFF_CONTROL, 32'h06, "trigger held");
    // freeze the block with the bus idle; the store must not run on meanwhile
    ce <= 1'b0;
    repeat (20) @(posedge clock);
    ce <= 1'b1;
    rdc(OFF_CONTROL, 32'h06, "frozen store");
    n = 0;
    while (rv[1] === 1'b1 && n < 40)
    begin
      bus(1'b0, OFF_CONTROL, 32'h0);
      chk("poll", rv[1] ? 32'h06 : 32'h04, rv);
      n++;
    end
    if (n >= 40)
    begin
      n_errors++;
      $display("[ERR] store trigger exp 0 got 1");
      print_verdict;
    end
    chk("store cleared", 32'h04, rv);
    exp_ee[a] = d;
    m_st = m_st | 1;
    ee_read(a);
    // broken unlock is refused, program space store is ignored
    store(a, ~d, 32'h06, 1'b1);
    m_st = m_st | 4;
    ee_read(a);
    store(a, ~d, 32'h86, 1'b0);
    repeat (SC + 2) @(posedge clock);
    m_ctl = 0;
    ee_read(a);
    rdc(OFF_IRQ_STATUS, m_st, "irq status");
    chk_irq(1'b0);
    wr(OFF_IRQ_STATUS, 32'h7);
    rdc(OFF_IRQ_STATUS, m_st, "status cleared");
    ee_read(a);
    wr(OFF_IRQ_MASK, 32'h5);
    chk_irq(1'b0);
    wr(OFF_IRQ_MASK, 32'h2);
    chk_irq(1'b1);
    wr(OFF_IRQ_STATUS, 32'h2);
    chk_irq(1'b0);
    // interrupted store: trigger cleared, abort flag up
    store(a, ~d, 32'h06, 1'b0);
    abort_cmd <= 1'b1;
    repeat (2) @(posedge clock);
    abort_cmd <= 1'b0;
    rdc(OFF_CONTROL, 32'h0c, "abort");
    // the interrupted byte must not have landed
    ee_read(a);
    // second reset in mid-run brings every register back to zero
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 9; i++)
      rdc(8'(i * 4), 32'h0, "reset again");
    print_verdict;
  end
endmodule : nvac_top_tb

// [nvac_unlock.sv]
// nvac_unlock: tracks the two-value unlock sequence that arms one byte store.
// assumes one-cycle write strobes from the bus slave on the same clock.
`timescale 1ns/1ps
module nvac_unlock
  import nvac_pkg::*;
(
  input wire logic clock, // core clock
  input wire logic rst, // async reset, active high
  input wire logic ce, // clock enable
  input wire logic port_wr, // write to the sequence port
  input wire logic ctl_wr, // write to the control register
  input wire logic other_wr, // write to any other register
  input wire logic [7:0] wdata, // bus write data
  output logic armed // sequence complete, next control write may store
);
  nvac_unlock_e state;

  // any stray write breaks the sequence; a control write consumes it
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      state <= UNL_IDLE;
    else if (ce)
    begin
      unique case (state)
        UNL_IDLE:
          if (port_wr && wdata == UNLOCK_FIRST) state <= UNL_FIRST;
        UNL_FIRST:
          if (port_wr && wdata == UNLOCK_SECOND) state <= UNL_ARMED;
          else if (port_wr || ctl_wr || other_wr) state <= UNL_IDLE;
        UNL_ARMED:
          if (port_wr || ctl_wr || other_wr) state <= UNL_IDLE;
        default: state <= UNL_IDLE;
      endcase
    end
  end

  assign armed = (state == UNL_ARMED);

  chk_unlock_order: assert property (@(posedge clock) disable iff (rst)
    $rose(armed) |-> $past(port_wr) && $past(wdata) == UNLOCK_SECOND)
    else $error("armed without the second unlock value");

endmodule : nvac_unlock
